// *** hdl/bsf_map.svh ***
// Constants of the backlight state and fault sequencer.
// Assumes inclusion by bare name from the package and the top module.
`ifndef BSF_MAP_SVH
`define BSF_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define BSF_CLK_HZ      125000000
`define BSF_DISCH_MS    9'd400
`define BSF_SOFT_MS     9'd25
`define BSF_BOOST_MS    9'd50
`define BSF_RECOV_MS    9'd100
`define BSF_BUSTO_MS    9'd500
`define BSF_SHORT_MS    3'd5

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BSF_ADR_BRT     8'h00
`define BSF_ADR_CUR     8'h04
`define BSF_ADR_IE      8'h08
`define BSF_ADR_STAT    8'h0C
`define BSF_ADR_DIAG    8'h10
`define BSF_ADR_CFG     8'h14

// ****************************************
// Fields and reset values
// ****************************************
`define BSF_NCH         4
`define BSF_NF          7
`define BSF_CLR_POS     8
`define BSF_F_CURRENT_SET_PIN      0
`define BSF_F_TSD       1
`define BSF_F_OPEN      2
`define BSF_F_SHORT     3
`define BSF_F_GND       4
`define BSF_F_INV       5
`define BSF_F_BUS       6
`define BSF_IE_DIS      2'b01
`define BSF_IE_ENA      2'b11
`define BSF_CURRENT_SET_PIN_CODE   12'h03FF
`define BSF_CUR_RST     12'h0FFF
`define BSF_BRT_RST     16'hFFFF

`endif

// *** hdl/bsf_pkg.sv ***
// Types of the backlight state and fault sequencer.
// Assumes bsf_map.svh is on the include path.
`include "bsf_map.svh"

package bsf_pkg;

    // ****************************************
    // Functional states
    // ****************************************
    typedef enum logic [3:0] {
        BSF_OFF    = 4'b0000,
        BSF_DISCH  = 4'b0001,
        BSF_INIT   = 4'b0010,
        BSF_STBY   = 4'b0011,
        BSF_SOFT   = 4'b0100,
        BSF_BOOST  = 4'b0101,
        BSF_NORMAL = 4'b0110,
        BSF_RECOV  = 4'b0111,
        BSF_LATCH  = 4'b1000
    } bsf_state_t;

    // Pin-side sense inputs, all asynchronous to the clock
    typedef struct packed {
        logic                     en;
        logic                     nvm_done;
        logic                     sense_done;
        logic [`BSF_NCH-1:0]      used;
        logic                     current_set_pin_low;
        logic                     over_temp;
        logic                     boost_at_max;
        logic                     bus_open;
        logic [`BSF_NCH-1:0]      hr_low;
        logic [`BSF_NCH-1:0]      hr_high;
        logic [`BSF_NCH-1:0]      gnd_low;
        logic [`BSF_NCH-1:0]      unused_open;
    } bsf_sense_t;

    // Power-train and housekeeping controls
    typedef struct packed {
        logic regulator_en;
        logic nvm_load;
        logic discharge;
        logic plsw_en;
        logic plsw_soft;
        logic boost_en;
        logic boost_ilim_low;
        logic vin_arm;
        logic gnd_test;
        logic boost_arm;
        logic led_arm;
        logic serial_rst;
    } bsf_pwr_t;

endpackage

// *** hdl/bsf_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is a slow level; no bus coherence across bits.
`timescale 1ns/1ps

module bsf_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule

// *** hdl/bsf_fsm.sv ***
// Backlight state sequencer with fault reactions and Wishbone registers.
// Assumes analog sense levels arrive asynchronously on sense_in.
`timescale 1ns/1ps
`include "bsf_map.svh"

module bsf_fsm
    import bsf_pkg::*;
#(
    parameter int MS_CYCLES = `BSF_CLK_HZ / 1000
) (
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire bsf_sense_t   sense_in,
    input  wire logic [7:0]   wb_adr_in,
    input  wire logic [31:0]  wb_dat_in,
    input  wire logic [3:0]   wb_sel_in,
    input  wire logic         wb_we_in,
    input  wire logic         wb_cyc_in,
    input  wire logic         wb_stb_in,
    output logic      [31:0]  wb_dat_out,
    output logic              wb_ack_out,
    output bsf_pwr_t          pwr_out,
    output logic      [3:0]   led_en_out,
    output logic      [11:0]  string_current_code_out,
    output logic              int_n_out
);

    // ****************************************
    // Input synchronisation and ms tick
    // ****************************************
    bsf_sense_t  s;
    logic [16:0] div_q;
    logic        tick_q;

    bsf_sync #(.W($bits(bsf_sense_t))) u_sync (
        .mclk_in (mclk_in),
        .rstn_in (rstn_in),
        .d_in    (sense_in),
        .q_out   (s)
    );

    // One-cycle enable every millisecond
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_q  <= 17'h0_0000;
            tick_q <= 1'b0;
        end else if (div_q == MS_CYCLES[16:0] - 17'd1) begin
            div_q  <= 17'h0_0000;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 17'd1;
            tick_q <= 1'b0;
        end
    end

    // ****************************************
    // State decode
    // ****************************************
    bsf_state_t      st_q;
    bsf_state_t      st_d;
    logic [8:0]      tmr_q;
    logic [15:0]     brt_q;
    logic [11:0]     cur_q;
    logic [3:0]      used_q;
    logic [3:0]      dis_q;
    logic [3:0]      led_q;
    logic [6:0]      fl_q;
    logic [6:0]      ie_q;
    logic [8:0]      bus_q;
    logic [2:0]      sh_q [4];

    wire run     = st_q inside {BSF_STBY, BSF_SOFT, BSF_BOOST, BSF_NORMAL};
    wire live    = st_q inside {BSF_SOFT, BSF_BOOST, BSF_NORMAL};
    wire powered = run || st_q inside {BSF_RECOV, BSF_LATCH};
    wire brt_nz  = |brt_q;
    wire [3:0] active  = used_q & ~dis_q;
    wire       all_dad = (|used_q) && !(|active);
    wire       init_ok = s.nvm_done && s.sense_done;

    // Ground check: soft start always, later only on dark channels
    wire [3:0] gnd_win = {4{st_q == BSF_SOFT}}
                       | ({4{st_q inside {BSF_BOOST, BSF_NORMAL}}} & ~led_q);
    wire [3:0] gnd_ch  = used_q & s.gnd_low & gnd_win;
    wire [3:0] open_ch = {4{st_q == BSF_NORMAL && s.boost_at_max}}
                       & led_q & s.hr_low;
    wire [3:0] sh_cond = {4{st_q == BSF_NORMAL && |(led_q & ~s.hr_high)}}
                       & led_q & s.hr_high;
    logic [3:0] short_ch;
    wire       bus_evt = s.bus_open && tick_q
                       && (bus_q >= `BSF_BUSTO_MS - 9'd1);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        case (st_q)
            BSF_OFF:    if (s.en) st_d = BSF_INIT;
            BSF_DISCH:  if (tmr_q >= `BSF_DISCH_MS) st_d = BSF_OFF;
            BSF_INIT:   if (init_ok) st_d = BSF_STBY;
            BSF_STBY:   if (!s.over_temp) st_d = BSF_SOFT;
            BSF_SOFT: begin
                if (|gnd_ch) st_d = BSF_RECOV;
                else if (tmr_q >= `BSF_SOFT_MS) st_d = BSF_BOOST;
            end
            BSF_BOOST: begin
                if (|gnd_ch) st_d = BSF_RECOV;
                else if (tmr_q >= `BSF_BOOST_MS) st_d = BSF_NORMAL;
            end
            BSF_NORMAL: if (|gnd_ch) st_d = BSF_RECOV;
            BSF_RECOV: begin
                if (tmr_q >= `BSF_RECOV_MS && s.en && brt_nz) begin
                    st_d = BSF_STBY;
                end
            end
            BSF_LATCH:  st_d = BSF_LATCH;
            default:    st_d = BSF_INIT;
        endcase
        // Hot die parks the sequence in standby
        if (live && s.over_temp) st_d = BSF_STBY;
        if (live && all_dad) st_d = BSF_LATCH;
        // Enable low beats everything once powered
        if (!s.en && !(st_q inside {BSF_OFF, BSF_DISCH})) begin
            st_d = BSF_DISCH;
        end
    end

    // State register and per-state ms timer
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q  <= BSF_INIT;
            tmr_q <= 9'h000;
        end else begin
            st_q <= st_d;
            if (st_d != st_q) tmr_q <= 9'h000;
            else if (tick_q && tmr_q != 9'h1FF) tmr_q <= tmr_q + 9'd1;
        end
    end

    // ****************************************
    // String bookkeeping
    // ****************************************
    // Short qualifier counters, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sh
            assign short_ch[gi] = sh_cond[gi] && tick_q
                                && sh_q[gi] >= `BSF_SHORT_MS;
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) sh_q[gi] <= 3'h0;
                else if (!sh_cond[gi]) sh_q[gi] <= 3'h0;
                else if (tick_q && sh_q[gi] != 3'h7) begin
                    sh_q[gi] <= sh_q[gi] + 3'd1;
                end
            end
        end
    endgenerate

    // Disabled strings stay out until the next power cycle
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            used_q <= 4'h0;
            dis_q  <= 4'h0;
            led_q  <= 4'h0;
        end else begin
            if (st_q == BSF_INIT) dis_q <= 4'h0;
            else dis_q <= dis_q | open_ch | short_ch;
            if (st_q == BSF_INIT && init_ok) used_q <= s.used;
            led_q <= (st_q == BSF_NORMAL && brt_nz)
                   ? active & ~open_ch & ~short_ch : 4'h0;
        end
    end

    // Bus watchdog: restarts while the transaction stays open
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) bus_q <= 9'h000;
        else if (!s.bus_open || bus_evt) bus_q <= 9'h000;
        else if (tick_q) bus_q <= bus_q + 9'd1;
    end

    // ****************************************
    // Fault flags and interrupt
    // ****************************************
    logic [6:0] evt;
    logic [6:0] clr;
    wire take   = wb_cyc_in && wb_stb_in && !wb_ack_out;
    // Write lands on the edge where the master sees ack
    wire cfg_ok = run || st_q inside {BSF_RECOV, BSF_LATCH};
    wire wr     = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out
               && cfg_ok;
    wire [15:0] wm  = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    wire [15:0] wd  = wb_dat_in[15:0];

    assign evt[`BSF_F_CURRENT_SET_PIN]  = powered && s.current_set_pin_low;
    assign evt[`BSF_F_TSD]   = run && s.over_temp;
    assign evt[`BSF_F_OPEN]  = |open_ch;
    assign evt[`BSF_F_SHORT] = |short_ch;
    assign evt[`BSF_F_GND]   = |gnd_ch;
    assign evt[`BSF_F_INV]   = run && |(~used_q & s.unused_open);
    assign evt[`BSF_F_BUS]   = bus_evt;
    // Clear needs flag bit and its clear bit together
    assign clr = (wr && wb_adr_in == `BSF_ADR_STAT)
               ? wd[6:0] & wd[`BSF_CLR_POS +: 7] & wm[6:0]
                 & wm[`BSF_CLR_POS +: 7]
               : 7'h00;

    // Hardware set wins over a same-cycle clear
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fl_q      <= 7'h00;
            int_n_out <= 1'b1;
        end else begin
            fl_q      <= (fl_q & ~clr) | evt;
            int_n_out <= !(|(fl_q & ie_q));
        end
    end

    // Interrupt enables: two-bit codes, other codes leave it alone
    logic [13:0] ie_rd;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_ie
            wire [1:0] code = wd[2*gi +: 2];
            wire       hit  = wr && wb_adr_in == `BSF_ADR_IE
                           && wm[2*gi] && wm[2*gi+1];
            assign ie_rd[2*gi +: 2] = {ie_q[gi], 1'b0};
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) ie_q[gi] <= 1'b1;
                else if (hit && code == `BSF_IE_DIS) ie_q[gi] <= 1'b0;
                else if (hit && code == `BSF_IE_ENA) ie_q[gi] <= 1'b1;
            end
        end
    endgenerate

    // ****************************************
    // Configuration registers and bus answer
    // ****************************************
    wire [31:0] rd =
        (wb_adr_in == `BSF_ADR_BRT)  ? {16'h0000, brt_q} :
        (wb_adr_in == `BSF_ADR_CUR)  ? {20'h0_0000, cur_q} :
        (wb_adr_in == `BSF_ADR_IE)   ? {18'h0_0000, ie_rd} :
        (wb_adr_in == `BSF_ADR_STAT) ? {25'h000_0000, fl_q} :
        (wb_adr_in == `BSF_ADR_DIAG) ? {24'h00_0000, dis_q, st_q} :
        (wb_adr_in == `BSF_ADR_CFG)  ? {28'h000_0000, used_q} :
        32'h0000_0000;

    // Current code is pinned in the powered states while the set resistor reads shorted
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            brt_q <= `BSF_BRT_RST;
            cur_q <= `BSF_CUR_RST;
        end else begin
            if (wr && wb_adr_in == `BSF_ADR_BRT) begin
                brt_q <= (brt_q & ~wm) | (wd & wm);
            end
            if (evt[`BSF_F_CURRENT_SET_PIN]) cur_q <= `BSF_CURRENT_SET_PIN_CODE;
            else if (wr && wb_adr_in == `BSF_ADR_CUR) begin
                cur_q <= (cur_q & ~wm[11:0]) | (wd[11:0] & wm[11:0]);
            end
        end
    end

    // Single-wait-state slave; unmapped reads return zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= take;
            if (take) wb_dat_out <= rd;
        end
    end

    // ****************************************
    // Power-train outputs
    // ****************************************
    bsf_pwr_t pwr_d;
    always_comb begin
        pwr_d                = '0;
        pwr_d.regulator_en   = st_q != BSF_OFF;
        pwr_d.nvm_load       = st_q == BSF_INIT;
        pwr_d.discharge      = st_q == BSF_DISCH;
        pwr_d.plsw_en        = live;
        pwr_d.plsw_soft      = st_q == BSF_SOFT;
        pwr_d.vin_arm        = live;
        pwr_d.gnd_test       = live;
        pwr_d.boost_en       = st_q inside {BSF_BOOST, BSF_NORMAL};
        pwr_d.boost_ilim_low = st_q == BSF_BOOST;
        pwr_d.boost_arm      = st_q inside {BSF_BOOST, BSF_NORMAL};
        pwr_d.led_arm        = st_q == BSF_NORMAL;
        pwr_d.serial_rst     = bus_evt;
    end

    // Recovery, latch and discharge all leave the train off
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwr_out    <= '0;
            led_en_out <= 4'h0;
            string_current_code_out <= `BSF_CUR_RST;
        end else begin
            pwr_out    <= pwr_d;
            // Gate with the state so drivers drop with led_arm
            led_en_out <= (st_q == BSF_NORMAL) ? led_q : 4'h0;
            string_current_code_out <= cur_q;
        end
    end

endmodule

// *** verif/bsf_fsm_monitor.sv ***
// Port checker for the backlight sequencer.
// Assumes it is bound into bsf_fsm and sees only its ports.
`timescale 1ns/1ps

module bsf_fsm_monitor
    import bsf_pkg::*;
#(
    parameter int MS_CYCLES = 125000
) (
    input wire logic        mclk_in,
    input wire logic        rstn_in,
    input wire bsf_sense_t  sense_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire bsf_pwr_t    pwr_out,
    input wire logic [3:0]  led_en_out,
    input wire logic [11:0] string_current_code_out
);
    // ****************************************
    // Run lengths
    // ****************************************
    logic [31:0] dis_q, sft_q, ilm_q, bus_q;

    // Phase lengths; cleared as soon as the phase drops
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dis_q <= '0;
            sft_q <= '0;
            ilm_q <= '0;
            bus_q <= '0;
        end else begin
            dis_q <= pwr_out.discharge ? dis_q + 32'h0000_0001 : '0;
            sft_q <= pwr_out.plsw_soft ? sft_q + 32'h0000_0001 : '0;
            ilm_q <= pwr_out.boost_ilim_low ? ilm_q + 32'h0000_0001 : '0;
            bus_q <= sense_in.bus_open ? bus_q + 32'h0000_0001 : '0;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    ack_reply_a:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered");
    ack_single_a:
    assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    disch_quiet_a:
    assert property (pwr_out.discharge |-> !pwr_out.boost_en &&
        !pwr_out.plsw_en && led_en_out == 4'h0)
        else $error("power on during discharge");
    disch_len_a:
    assert property ($fell(pwr_out.discharge) |->
        dis_q >= 399*MS_CYCLES && dis_q <= 402*MS_CYCLES)
        else $error("discharge length wrong");
    en_off_a:
    assert property ($fell(sense_in.en) |-> ##[1:6]
        (!pwr_out.boost_en && led_en_out == 4'h0))
        else $error("enable low did not stop power");
    soft_len_a:
    assert property ($fell(pwr_out.plsw_soft) && pwr_out.boost_ilim_low |->
        sft_q >= 24*MS_CYCLES && sft_q <= 27*MS_CYCLES)
        else $error("soft start length wrong");
    soft_arm_a:
    assert property (pwr_out.plsw_soft |-> pwr_out.vin_arm && pwr_out.plsw_en)
        else $error("soft start not armed");
    boost_len_a:
    assert property ($fell(pwr_out.boost_ilim_low) && pwr_out.led_arm |->
        ilm_q >= 49*MS_CYCLES && ilm_q <= 52*MS_CYCLES)
        else $error("boost start length wrong");
    led_gate_a:
    assert property (led_en_out != 4'h0 |-> pwr_out.led_arm &&
        pwr_out.boost_en)
        else $error("drivers on outside normal");
    current_set_pin_code_a:
    assert property ((sense_in.current_set_pin_low && pwr_out.led_arm) [*5] |->
        string_current_code_out == 12'h3FF)
        else $error("current code not forced");
    bus_reset_a:
    assert property (pwr_out.serial_rst |-> (bus_q >= 499*MS_CYCLES)
        ##1 !pwr_out.serial_rst)
        else $error("serial reset out of place");
endmodule

bind bsf_fsm bsf_fsm_monitor #(.MS_CYCLES(MS_CYCLES)) bsf_fsm_monitor_inst (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .sense_in(sense_in),
    .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in),
    .wb_ack_out(wb_ack_out),
    .pwr_out(pwr_out),
    .led_en_out(led_en_out),
    .string_current_code_out(string_current_code_out)
);

// *** verif/bsf_plant.sv ***
// Power train and memory model facing the sequencer.
// Assumes the regulator enable marks a powered device.
`timescale 1ns/1ps

module bsf_plant
    import bsf_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    input  wire bsf_pwr_t   pwr_in,
    input  wire logic [3:0] used_in,
    input  wire logic       gnd_fault_in,
    output logic            nvm_done_out,
    output logic            sense_done_out,
    output logic [3:0]      gnd_low_out
);
    logic [5:0] load_q;

    // Load and sensing take a while; restart on every power-up
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in)
            load_q <= '0;
        else if (!pwr_in.regulator_en)
            load_q <= '0;
        else if (load_q != 6'h3F)
            load_q <= load_q + 6'h01;
    end

    assign nvm_done_out   = load_q >= 6'h28;
    assign sense_done_out = load_q >= 6'h30;
    // Ground short shows only under test current
    assign gnd_low_out = pwr_in.gnd_test ? {4{gnd_fault_in}} & used_in : 4'h0;
endmodule

// *** verif/bsf_fsm_tb.sv ***
// Testbench for the backlight sequencer.
// Assumes the plant model drives load and ground-test sense lines.
`timescale 1ns/1ps
`include "bsf_map.svh"

module bsf_fsm_tb;
    import bsf_pkg::*;
    localparam int MS = 10;
    logic mclk_in, rstn_in, cyc, stb, we, gf, nd, sd;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, failures, comparisons;
    logic [3:0] gl;
    bsf_sense_t drv, sns;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, int_n_out;
    bsf_pwr_t pwr_out;
    logic [3:0] led_en_out;
    logic [11:0] code;

    // ****************************************
    // Wiring
    // ****************************************
    assign sns = {drv.en, nd, sd, drv[23:8], gl, drv.unused_open};
    bsf_fsm #(.MS_CYCLES(MS)) bsf_fsm_inst (.mclk_in(mclk_in),
        .rstn_in(rstn_in), .sense_in(sns), .wb_adr_in(adr),
        .wb_dat_in(wdat), .wb_sel_in(4'hF), .wb_we_in(we),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .pwr_out(pwr_out),
        .led_en_out(led_en_out), .string_current_code_out(code),
        .int_n_out(int_n_out));
    bsf_plant bsf_plant_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .pwr_in(pwr_out), .used_in(drv.used), .gnd_fault_in(gf),
        .nvm_done_out(nd), .sense_done_out(sd), .gnd_low_out(gl));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle; held until ack, released after it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
        rdat = wb_dat_out;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Poll the state field; give up and check after 2500 reads
    task automatic wst(input bsf_state_t s);
        for (int i = 0; i < 2500; i++) begin
            bus(1'b0, `BSF_ADR_DIAG, 32'h0);
            if (rdat[3:0] === s) break;
        end
        chk(rdat[3:0], s);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic results;
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog, tests
    // ****************************************
    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end
    // Whole run is about 13k cycles
    initial begin
        tk(80000);
        failures = failures + 1;
        results;
    end
    initial begin
        failures = 0; comparisons = 0; cyc = 0; stb = 0; we = 0;
        adr = 0; wdat = 0; gf = 0; rstn_in = 0;
        drv = '0;
        drv.en = 1'b1;
        drv.used = 4'h7;
        tk(8);
        rstn_in <= 1'b1;
        tk(1);
        bus(1'b1, `BSF_ADR_BRT, 32'h0000_1234);
        rc(`BSF_ADR_BRT, 32'h0000_FFFF);
        rc(`BSF_ADR_CUR, 32'h0000_0FFF);
        rc(`BSF_ADR_IE, 32'h0000_2AAA);
        rc(8'h20, 32'h0);
        wst(BSF_NORMAL);
        chk(led_en_out, 4'h7);
        bus(1'b1, `BSF_ADR_BRT, 32'h0);
        tk(6);
        chk(led_en_out, 4'h0);
        bus(1'b1, `BSF_ADR_BRT, 32'h0000_00AB);
        rc(`BSF_ADR_BRT, 32'h0000_00AB);
        drv.current_set_pin_low <= 1'b1;
        tk(8);
        chk(code, 12'h3FF);
        chk(int_n_out, 1'b0);
        rc(`BSF_ADR_DIAG, 32'h6);
        drv.current_set_pin_low <= 1'b0;
        tk(8);
        bus(1'b1, `BSF_ADR_STAT, 32'h1);
        rc(`BSF_ADR_STAT, 32'h1);
        bus(1'b1, `BSF_ADR_STAT, 32'h0000_0101);
        rc(`BSF_ADR_STAT, 32'h0);
        chk(int_n_out, 1'b1);
        bus(1'b1, `BSF_ADR_IE, 32'h0000_3FFD);
        rc(`BSF_ADR_IE, 32'h0000_2AA8);
        drv.current_set_pin_low <= 1'b1;
        tk(8);
        chk(int_n_out, 1'b1);
        bus(1'b1, `BSF_ADR_IE, 32'h0000_3FFF);
        // Interrupt pin follows the enable one edge later
        tk(2);
        chk(int_n_out, 1'b0);
        drv.current_set_pin_low <= 1'b0;
        drv.unused_open[3] <= 1'b1;
        tk(8);
        rc(`BSF_ADR_STAT, 32'h21);
        rc(`BSF_ADR_DIAG, 32'h6);
        drv.unused_open[3] <= 1'b0;
        // Let the level leave the synchroniser; set beats clear
        tk(4);
        bus(1'b1, `BSF_ADR_STAT, 32'h0000_2121);
        drv.bus_open <= 1'b1;
        tk(500 * MS + 20);
        rc(`BSF_ADR_STAT, 32'h40);
        drv.bus_open <= 1'b0;
        rc(`BSF_ADR_DIAG, 32'h6);
        bus(1'b1, `BSF_ADR_STAT, 32'h0000_4040);
        drv.hr_low[0] <= 1'b1;
        drv.boost_at_max <= 1'b1;
        tk(8);
        chk(led_en_out, 4'h6);
        rc(`BSF_ADR_DIAG, 32'h16);
        drv.hr_low[0] <= 1'b0;
        drv.boost_at_max <= 1'b0;
        bus(1'b1, `BSF_ADR_STAT, 32'h0000_0404);
        drv.hr_high[1] <= 1'b1;
        tk(4 * MS);
        rc(`BSF_ADR_STAT, 32'h0);
        tk(3 * MS);
        rc(`BSF_ADR_STAT, 32'h8);
        chk(led_en_out, 4'h4);
        drv.hr_high[1] <= 1'b0;
        bus(1'b1, `BSF_ADR_STAT, 32'h0000_0808);
        drv.over_temp <= 1'b1;
        tk(8);
        rc(`BSF_ADR_DIAG, 32'h33);
        rc(`BSF_ADR_STAT, 32'h2);
        gf <= 1'b1;
        drv.over_temp <= 1'b0;
        wst(BSF_RECOV);
        chk({pwr_out.plsw_en, pwr_out.boost_en, led_en_out}, 6'h0);
        rc(`BSF_ADR_STAT, 32'h12);
        gf <= 1'b0;
        bus(1'b1, `BSF_ADR_BRT, 32'h0);
        tk(120 * MS);
        rc(`BSF_ADR_DIAG, 32'h37);
        bus(1'b1, `BSF_ADR_BRT, 32'h0000_00AB);
        wst(BSF_NORMAL);
        drv.hr_low[2] <= 1'b1;
        drv.boost_at_max <= 1'b1;
        tk(8);
        drv.hr_low[2] <= 1'b0;
        tk(10);
        rc(`BSF_ADR_DIAG, 32'h78);
        drv.en <= 1'b0;
        tk(8);
        chk(pwr_out.discharge, 1'b1);
        wst(BSF_OFF);
        bus(1'b1, `BSF_ADR_BRT, 32'h0000_0055);
        rc(`BSF_ADR_BRT, 32'h0000_00AB);
        drv.boost_at_max <= 1'b0;
        drv.en <= 1'b1;
        wst(BSF_NORMAL);
        chk(led_en_out, 4'h7);
        results;
    end
endmodule
